// *** common/exc_pkg.sv ***
// Shared constants and types of the exception vectoring unit
package exc_pkg;
  // ----------------------------------------
  // Vector table
  // ----------------------------------------
  localparam int          VEC_TABLE_ENTRIES = 256;
  localparam int          VEC_TABLE_BYTES   = 1024;
  localparam int          VEC_NUM_W         = 8;
  localparam int          VEC_OFS_SHIFT     = 2;
  localparam logic [31:0] VTB_RESET         = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP         = 32'h0000_0002;

  // ----------------------------------------
  // Status register fields
  // ----------------------------------------
  localparam int          SR_T1_BIT    = 15;
  localparam int          SR_T0_BIT    = 14;
  localparam int          SR_S_BIT     = 13;
  localparam int          SR_IMASK_LO  = 8;
  localparam int          SR_IMASK_HI  = 10;

  // ----------------------------------------
  // Stack frame
  // ----------------------------------------
  localparam logic [3:0]  FMT_FOUR_WORD = 4'h0;
  localparam logic [3:0]  FMT_SIX_WORD  = 4'h2;
  localparam logic [31:0] FRAME4_BYTES  = 32'h0000_0008;
  localparam logic [31:0] FRAME6_BYTES  = 32'h0000_000C;
  localparam logic [31:0] FMT_WORD_OFS  = 32'h0000_0006;
  localparam logic [1:0]  FRAME4_LAST   = 2'h3;

  // ----------------------------------------
  // Internally generated vector numbers
  // ----------------------------------------
  localparam logic [7:0]  VEC_ILLEGAL    = 8'h04;
  localparam logic [7:0]  VEC_LINE_F     = 8'h0B;
  localparam logic [7:0]  VEC_FORMAT_ERR = 8'h0E;

  // ----------------------------------------
  // Unimplemented opcode patterns (mask, match)
  // ----------------------------------------
  localparam logic [15:0] BITFIELD_MASK  = 16'hF8C0;
  localparam logic [15:0] BITFIELD_MATCH = 16'hE8C0;
  localparam logic [15:0] MODULE_MASK    = 16'hFFC0;
  localparam logic [15:0] MODULE_MATCH   = 16'h06C0;
  localparam logic [15:0] CAS_MASK       = 16'hF9C0;
  localparam logic [15:0] CAS_MATCH      = 16'h08C0;
  localparam logic [15:0] CAS_SIZE_MASK  = 16'h0600;
  localparam logic [15:0] BCD_MASK       = 16'hF130;
  localparam logic [15:0] BCD_MATCH      = 16'h8100;
  localparam logic [15:0] BCD_SEL_MASK   = 16'h00C0;
  localparam logic [15:0] LINE_F_MASK    = 16'hF000;
  localparam logic [15:0] LINE_F_MATCH   = 16'hF000;
  localparam logic [2:0]  CP_ID_NATIVE   = 3'h4;

  typedef enum logic [3:0] {
    st_idle, st_snap, st_vec, st_push, st_fetch, st_load, st_rfmt, st_rword
  } exc_state_e;
endpackage : exc_pkg

// *** src/exception_vectoring_unit.sv ***
// Exception vectoring unit: vector lookup, frame push and return-from-exception
`timescale 1ns/1ps
module exception_vectoring_unit (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        vtb_wr,
  input  wire logic [31:0] vtb_wdata,
  input  wire logic [15:0] sr_in,
  input  wire logic [31:0] pc_in,
  input  wire logic [31:0] supervisor_stack_pointer,
  input  wire logic [31:0] user_stack_pointer,
  input  wire logic        exc_req,
  input  wire logic [7:0]  exc_vec_num,
  input  wire logic        decode_valid,
  input  wire logic [15:0] opword,
  input  wire logic        ea_illegal,
  input  wire logic        irq_req,
  input  wire logic [2:0]  irq_level,
  input  wire logic        ext_vec_valid,
  input  wire logic [7:0]  ext_vec_num,
  input  wire logic        return_from_exception_op,
  input  wire logic        loop_active,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic [31:0]      vector_table_base,
  output logic [31:0]      active_sp,
  output logic             busy,
  output logic             iack,
  output logic             loop_exit,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  output logic             ctx_load,
  output logic [15:0]      new_sr,
  output logic [31:0]      new_pc,
  output logic [31:0]      new_supervisor_stack_pointer
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    exc_pkg::exc_state_e st;
    logic [31:0]         vtb;
    logic [31:0]         asp;
    logic [15:0]         sr_snap;
    logic [31:0]         pc_snap;
    logic [15:0]         sr_work;
    logic [7:0]          vec;
    logic                ext_src;
    logic [31:0]         sp;
    logic [31:0]         frame_len;
    logic [1:0]          wi;
    logic [15:0]         hi_word;
    logic                busy;
    logic                iack;
    logic                loop_exit;
    logic                mem_req;
    logic                mem_we;
    logic [31:0]         mem_addr;
    logic [15:0]         mem_wdata;
    logic                ctx_load;
    logic [15:0]         new_sr;
    logic [31:0]         new_pc;
    logic [31:0]         new_supervisor_stack_pointer;
  } evu_s;

  evu_s s_q;
  evu_s s_d;

  logic        trap_hit;
  logic [7:0]  trap_vec;
  logic [31:0] vec_ofs;
  logic [31:0] vec_addr;
  logic [15:0] fv_word;

  opcode_trap_decode opcode_trap_decode_inst (
    .opword     (opword),
    .ea_illegal (ea_illegal),
    .trap_hit   (trap_hit),
    .trap_vec   (trap_vec)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.loop_exit = 1'b0;
    s_d.ctx_load  = 1'b0;
    vec_ofs  = {22'h0, s_q.vec, 2'h0};
    vec_addr = 32'(s_q.vtb + vec_ofs);
    fv_word  = {exc_pkg::FMT_FOUR_WORD, vec_ofs[11:0]};
    if (vtb_wr)
    begin
      s_d.vtb = vtb_wdata;
    end
    s_d.asp = sr_in[exc_pkg::SR_S_BIT] ? supervisor_stack_pointer : user_stack_pointer;
    unique case (s_q.st)
      exc_pkg::st_idle:
      begin
        if ((decode_valid && trap_hit) || exc_req || irq_req)
        begin
          s_d.ext_src = !(decode_valid && trap_hit) && !exc_req && irq_req;
          s_d.vec     = (decode_valid && trap_hit) ? trap_vec : exc_vec_num;
          s_d.st      = exc_pkg::st_snap;
          s_d.busy    = 1'b1;
        end
        else if (return_from_exception_op)
        begin
          s_d.sp       = supervisor_stack_pointer;
          s_d.mem_req  = 1'b1;
          s_d.mem_we   = 1'b0;
          s_d.mem_addr = 32'(supervisor_stack_pointer + exc_pkg::FMT_WORD_OFS);
          s_d.st       = exc_pkg::st_rfmt;
          s_d.busy     = 1'b1;
        end
      end
      exc_pkg::st_snap:
      begin
        s_d.sr_snap = sr_in;
        s_d.pc_snap = pc_in;
        s_d.sr_work = sr_in;
        s_d.sr_work[exc_pkg::SR_S_BIT]  = 1'b1;
        s_d.sr_work[exc_pkg::SR_T1_BIT] = 1'b0;
        s_d.sr_work[exc_pkg::SR_T0_BIT] = 1'b0;
        if (s_q.ext_src)
        begin
          s_d.sr_work[exc_pkg::SR_IMASK_HI:exc_pkg::SR_IMASK_LO] = irq_level;
        end
        s_d.loop_exit = loop_active;
        s_d.iack      = s_q.ext_src;
        s_d.st        = exc_pkg::st_vec;
      end
      exc_pkg::st_vec:
      begin
        if (!s_q.ext_src || ext_vec_valid)
        begin
          if (s_q.ext_src)
          begin
            s_d.vec = ext_vec_num;
          end
          s_d.iack      = 1'b0;
          s_d.sp        = 32'(supervisor_stack_pointer - exc_pkg::FRAME4_BYTES);
          s_d.wi        = 2'h0;
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b1;
          s_d.mem_addr  = 32'(supervisor_stack_pointer - exc_pkg::FRAME4_BYTES);
          s_d.mem_wdata = s_q.sr_snap;
          s_d.st        = exc_pkg::st_push;
        end
      end
      exc_pkg::st_push:
      begin
        if (mem_ack)
        begin
          if (s_q.wi == exc_pkg::FRAME4_LAST)
          begin
            s_d.mem_we   = 1'b0;
            s_d.mem_addr = vec_addr;
            s_d.wi       = 2'h0;
            s_d.st       = exc_pkg::st_fetch;
          end
          else
          begin
            s_d.wi       = 2'(s_q.wi + 2'h1);
            s_d.mem_addr = 32'(s_q.mem_addr + exc_pkg::WORD_STEP);
            unique case (s_q.wi)
              2'h0: s_d.mem_wdata = s_q.pc_snap[31:16];
              2'h1: s_d.mem_wdata = s_q.pc_snap[15:0];
              2'h2: s_d.mem_wdata = fv_word;
              2'h3: s_d.mem_wdata = fv_word;
            endcase
          end
        end
      end
      exc_pkg::st_fetch:
      begin
        if (mem_ack)
        begin
          if (s_q.wi == 2'h0)
          begin
            s_d.hi_word  = mem_rdata;
            s_d.wi       = 2'h1;
            s_d.mem_addr = 32'(s_q.mem_addr + exc_pkg::WORD_STEP);
          end
          else
          begin
            s_d.mem_req = 1'b0;
            s_d.new_pc  = {s_q.hi_word, mem_rdata};
            s_d.new_sr  = s_q.sr_work;
            s_d.new_supervisor_stack_pointer = s_q.sp;
            s_d.st      = exc_pkg::st_load;
          end
        end
      end
      exc_pkg::st_load:
      begin
        s_d.ctx_load = 1'b1;
        s_d.busy     = 1'b0;
        s_d.st       = exc_pkg::st_idle;
      end
      exc_pkg::st_rfmt:
      begin
        if (mem_ack)
        begin
          if (mem_rdata[15:12] == exc_pkg::FMT_FOUR_WORD
              || mem_rdata[15:12] == exc_pkg::FMT_SIX_WORD)
          begin
            s_d.frame_len = (mem_rdata[15:12] == exc_pkg::FMT_FOUR_WORD) ?
                            exc_pkg::FRAME4_BYTES : exc_pkg::FRAME6_BYTES;
            s_d.mem_addr  = s_q.sp;
            s_d.wi        = 2'h0;
            s_d.st        = exc_pkg::st_rword;
          end
          else
          begin
            s_d.mem_req = 1'b0;
            s_d.ext_src = 1'b0;
            s_d.vec     = exc_pkg::VEC_FORMAT_ERR;
            s_d.st      = exc_pkg::st_snap;
          end
        end
      end
      exc_pkg::st_rword:
      begin
        if (mem_ack)
        begin
          s_d.wi       = 2'(s_q.wi + 2'h1);
          s_d.mem_addr = 32'(s_q.mem_addr + exc_pkg::WORD_STEP);
          unique case (s_q.wi)
            2'h0: s_d.new_sr  = mem_rdata;
            2'h1: s_d.hi_word = mem_rdata;
            default:
            begin
              s_d.mem_req = 1'b0;
              s_d.new_pc  = {s_q.hi_word, mem_rdata};
              s_d.new_supervisor_stack_pointer = 32'(s_q.sp + s_q.frame_len);
              s_d.st      = exc_pkg::st_load;
            end
          endcase
        end
      end
      default:
      begin
        s_d.st = exc_pkg::st_idle;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_q     <= '0;
      s_q.st  <= exc_pkg::st_idle;
      s_q.vtb <= exc_pkg::VTB_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign vector_table_base = s_q.vtb;
  assign active_sp         = s_q.asp;
  assign busy              = s_q.busy;
  assign iack              = s_q.iack;
  assign loop_exit         = s_q.loop_exit;
  assign mem_req           = s_q.mem_req;
  assign mem_we            = s_q.mem_we;
  assign mem_addr          = s_q.mem_addr;
  assign mem_wdata         = s_q.mem_wdata;
  assign ctx_load          = s_q.ctx_load;
  assign new_sr            = s_q.new_sr;
  assign new_pc            = s_q.new_pc;
  assign new_supervisor_stack_pointer = s_q.new_supervisor_stack_pointer;
endmodule : exception_vectoring_unit

// *** src/opcode_trap_decode.sv ***
// Unimplemented opcode and illegal addressing mode trap decoder
`timescale 1ns/1ps
module opcode_trap_decode (
  input  wire logic [15:0] opword,
  input  wire logic        ea_illegal,
  output logic             trap_hit,
  output logic [7:0]       trap_vec
);
  logic bit_field_ops;
  logic module_ops;
  logic dual_compare_and_set_op;
  logic bcd_ops;
  logic coproc_ops;

  always_comb
  begin
    bit_field_ops = (opword & exc_pkg::BITFIELD_MASK) == exc_pkg::BITFIELD_MATCH;
    module_ops   = (opword & exc_pkg::MODULE_MASK) == exc_pkg::MODULE_MATCH;
    // Compare-and-set pairs, size field zero is a different opcode
    dual_compare_and_set_op = ((opword & exc_pkg::CAS_MASK) == exc_pkg::CAS_MATCH)
                              && ((opword & exc_pkg::CAS_SIZE_MASK) != 16'h0000);
    // Pack and bcd_unpack_op: select bits 01 or 10; 00 and 11 are decimal subtract and divide
    bcd_ops      = ((opword & exc_pkg::BCD_MASK) == exc_pkg::BCD_MATCH)
                   && (^(opword & exc_pkg::BCD_SEL_MASK));
    // Line F except the native table and stop group
    coproc_ops   = ((opword & exc_pkg::LINE_F_MASK) == exc_pkg::LINE_F_MATCH)
                   && (opword[11:9] != exc_pkg::CP_ID_NATIVE);
    trap_hit = bit_field_ops || module_ops || dual_compare_and_set_op
               || bcd_ops || coproc_ops || ea_illegal;
    trap_vec = coproc_ops ? exc_pkg::VEC_LINE_F : exc_pkg::VEC_ILLEGAL;
  end
endmodule : opcode_trap_decode

// *** tb/evu_assertions.sv ***
// Port-level assertions of the exception vectoring unit
`timescale 1ns/1ps
module evu_assertions (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        busy,
  input wire logic        iack,
  input wire logic        ext_vec_valid,
  input wire logic        loop_exit,
  input wire logic        ctx_load,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic [31:0] vector_table_base
);
  logic        wr_q;
  logic [15:0] ofs_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Last frame word written holds the vector offset
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wr_q  <= 1'b0;
      ofs_q <= 16'h0;
    end
    else
    begin
      wr_q <= mem_req && mem_we;
      if (mem_req && mem_we && mem_ack)
        ofs_q <= mem_wdata;
    end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ctx_pulse: assert property (ctx_load |=> !ctx_load)
    else $error("ctx_load longer than one cycle");
  a_ctx_idle: assert property (ctx_load |-> !busy && !mem_req)
    else $error("ctx_load while still busy");
  a_idle_quiet: assert property (!busy |-> !mem_req && !iack)
    else $error("bus or iack active while idle");
  a_loop_pulse: assert property (loop_exit |=> !loop_exit)
    else $error("loop_exit longer than one cycle");
  a_loop_busy: assert property (loop_exit |-> busy && !ctx_load)
    else $error("loop_exit outside exception entry");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before ack");
  a_word_step: assert property (mem_req && mem_we && mem_ack |=> !mem_we || mem_addr == $past(mem_addr) + 32'h2)
    else $error("frame word address not consecutive");
  a_vec_addr: assert property (mem_req && !mem_we && wr_q |-> mem_addr == vector_table_base + {20'h0, ofs_q[11:0]})
    else $error("vector fetch address wrong");
  a_iack_hold: assert property (iack && !ext_vec_valid |=> iack)
    else $error("iack dropped before vector supplied");
  a_iack_drop: assert property (iack && ext_vec_valid |-> ##[1:2] !iack)
    else $error("iack held after vector supplied");

  c_ctx: cover property (ctx_load);
  c_loop: cover property (loop_exit);
  c_ext: cover property (iack && ext_vec_valid);
endmodule : evu_assertions

// *** tb/exc_far_model.sv ***
// Far-side model: word memory with vector table and external vectoring device
`timescale 1ns/1ps
module exc_far_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        iack,
  input  wire logic [7:0]  dev_vec,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata,
  output logic             ext_vec_valid,
  output logic [7:0]       ext_vec_num
);
  logic [15:0] mem [logic [31:0]];
  int          mwait;
  int          iwait;
  logic        served;

  function automatic logic [15:0] tw(input logic [31:0] a);
    return a[15:0] ^ 16'hC3A5;
  endfunction : tw

  // ----------------------------------------
  // Memory answers promptly or slowly; data lines scramble when idle
  // ----------------------------------------
  always @(posedge mclk or posedge rst)
    if (rst)
    begin
      {mem_ack, mem_rdata, mwait} <= '0;
    end
    else if (mem_req && !mem_ack && mwait == 0)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
        mem[mem_addr] = mem_wdata;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : tw(mem_addr);
      mwait <= $urandom_range(3);
    end
    else
    begin
      if (mem_req && !mem_ack)
        mwait <= mwait - 1;
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end

  always @(posedge mclk or posedge rst)
    if (rst)
    begin
      {ext_vec_valid, ext_vec_num, served} <= '0;
      iwait <= 2;
    end
    else if (iack && !served && iwait == 0)
    begin
      ext_vec_valid <= 1'b1;
      ext_vec_num   <= dev_vec;
      served        <= 1'b1;
      iwait         <= $urandom_range(4);
    end
    else
    begin
      if (iack && !served)
        iwait <= iwait - 1;
      if (!iack)
        served <= 1'b0;
      ext_vec_valid <= 1'b0;
      ext_vec_num   <= ~ext_vec_num;
    end
endmodule : exc_far_model

// *** tb/exception_vectoring_unit_tb.sv ***
// Self-checking bench of the exception vectoring unit
`timescale 1ns/1ps
module exception_vectoring_unit_tb;
  logic        mclk, rst, vtb_wr, exc_req, decode_valid, ea_illegal, irq_req, loop_active;
  logic        return_from_exception_op;
  logic        mem_ack, ext_vec_valid, busy, iack, loop_exit, mem_req, mem_we, ctx_load, saw_loop, saw_iack;
  logic [2:0]  irq_level;
  logic [7:0]  exc_vec_num, ext_vec_num, dev_vec;
  logic [15:0] sr_in, opword, mem_rdata, mem_wdata, new_sr;
  logic [31:0] vtb_wdata, pc_in, supervisor_stack_pointer, user_stack_pointer, vector_table_base, active_sp;
  logic [31:0] mem_addr, new_pc, new_supervisor_stack_pointer;
  logic [16:0] ops [8] = '{17'h0E8C0, 17'h006C0, 17'h00AC0, 17'h00EFC, 17'h08140, 17'h08180, 17'h14E71, 17'h0F000};
  int          n_mismatch, cmp_count;

  exception_vectoring_unit exception_vectoring_unit_inst (.*);
  exc_far_model exc_far_model_inst (.*);

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (loop_exit)
      saw_loop <= 1'b1;
    if (iack)
      saw_iack <= 1'b1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [15:0] tw(input logic [31:0] a);
    return a[15:0] ^ 16'hC3A5;
  endfunction : tw

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic wait_ctx();
    int k;
    for (k = 0; k < 400 && ctx_load !== 1'b1; k++)
      @(negedge mclk);
    if (k == 400)
      chk(32'h0, 32'h1, "hang");
  endtask : wait_ctx

  task automatic set_vtb(input logic [31:0] v);
    @(posedge mclk);
    {vtb_wr, vtb_wdata} <= {1'b1, v};
    @(posedge mclk);
    vtb_wr <= 1'b0;
    @(negedge mclk);
    chk(vector_table_base, v, "base");
  endtask : set_vtb

  task automatic do_exc(input int kind, input logic [7:0] ev, input logic [16:0] op, input logic [31:0] sp);
    logic [31:0] pc, usr, va;
    logic [15:0] sr, s;
    logic        lp;
    pc  = $urandom;
    usr = $urandom;
    sr  = $urandom;
    lp  = kind < 3 ? $urandom_range(1) : 1'b0;
    @(posedge mclk);
    {sr_in, pc_in, supervisor_stack_pointer, user_stack_pointer, loop_active, {ea_illegal, opword}}
      <= {sr, pc, sp, usr, lp, op};
    // Only a plain internal exception may use exc_vec_num; elsewhere it must be ignored
    {saw_loop, saw_iack, exc_vec_num, dev_vec, irq_level} <= {2'h0, ((kind == 0) ? ev : ~ev), ev, sr[2:0]};
    {exc_req, decode_valid, irq_req, return_from_exception_op} <= 4'h8 >> kind;
    @(posedge mclk);
    {exc_req, decode_valid, irq_req, return_from_exception_op} <= 4'h0;
    wait_ctx();
    va = vtb_wdata + {22'h0, ev, 2'h0};
    s  = {3'h1, sr[12:0]};
    if (kind == 2)
      s[10:8] = sr[2:0];
    chk(new_pc, {tw(va), tw(va + 32'h2)}, "pc");
    chk(new_sr, s, "sr");
    chk(new_supervisor_stack_pointer, sp - 32'h8, "sup_sp");
    chk(exc_far_model_inst.mem[sp - 32'h8], sr, "fsr");
    chk({exc_far_model_inst.mem[sp - 32'h6], exc_far_model_inst.mem[sp - 32'h4]}, pc, "fpc");
    chk(exc_far_model_inst.mem[sp - 32'h2], {6'h0, ev, 2'h0}, "fofs");
    chk(saw_loop, lp, "loop");
    chk(saw_iack, kind == 2, "iack");
    chk(active_sp, sr[13] ? sp : usr, "asp");
  endtask : do_exc

  task automatic do_return(input logic [31:0] sp, input logic [15:0] sr, input logic [31:0] pc,
                           input logic [31:0] len);
    @(posedge mclk);
    {supervisor_stack_pointer, return_from_exception_op} <= {sp, 1'b1};
    @(posedge mclk);
    return_from_exception_op <= 1'b0;
    wait_ctx();
    chk(new_sr, sr, "rsr");
    chk(new_pc, pc, "rpc");
    chk(new_supervisor_stack_pointer, sp + len, "rsp");
  endtask : do_return

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {vtb_wr, exc_req, decode_valid, ea_illegal, irq_req, return_from_exception_op, loop_active} = 7'h0;
    {vtb_wdata, sr_in, pc_in, supervisor_stack_pointer, user_stack_pointer, opword} = 160'h0;
    {exc_vec_num, dev_vec, irq_level} = 19'h0;
    {n_mismatch, cmp_count} = 64'h0;
    void'($urandom(32'h4604));
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({busy, mem_req, ctx_load, iack}, 4'h0, "rst");
    chk(vector_table_base, 32'h0, "rvtb");
    $display("test reset done");
    set_vtb(32'hFFFF_FF80);
    do_exc(0, 8'hFF, 17'h0, 32'h0000_2000);
    do_return(32'h0000_1FF8, sr_in, pc_in, 32'h8);
    set_vtb(32'h0001_0000);
    do_exc(0, 8'h00, 17'h0, 32'h0000_2000);
    $display("test bounds done");
    repeat (8)
    begin
      set_vtb($urandom & 32'hFFFF_FFFC);
      do_exc($urandom_range(1) * 2, $urandom, 17'h0, $urandom & 32'hFFFF_FFFE);
      do_return(supervisor_stack_pointer - 32'h8, sr_in, pc_in, 32'h8);
    end
    $display("test random done");
    foreach (ops[i])
      do_exc(1, i == 7 ? exc_pkg::VEC_LINE_F : exc_pkg::VEC_ILLEGAL, ops[i], 32'h0000_4000);
    @(posedge mclk);
    {decode_valid, ea_illegal, opword} <= {2'h2, 16'h4E71};
    @(posedge mclk);
    decode_valid <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(busy, 1'b0, "notrap");
    $display("test traps done");
    exc_far_model_inst.mem[32'h0000_5000] = 16'hA5A5;
    exc_far_model_inst.mem[32'h0000_5002] = 16'h1234;
    exc_far_model_inst.mem[32'h0000_5004] = 16'h5678;
    exc_far_model_inst.mem[32'h0000_5006] = 16'h2018;
    do_return(32'h0000_5000, 16'hA5A5, 32'h1234_5678, 32'hC);
    exc_far_model_inst.mem[32'h0000_3006] = 16'h7000;
    do_exc(3, exc_pkg::VEC_FORMAT_ERR, 17'h0, 32'h0000_3000);
    $display("test format done");
    give_verdict();
  end

  initial
  begin
    #400000;
    chk(32'h0, 32'h1, "watchdog");
    give_verdict();
  end
endmodule : exception_vectoring_unit_tb

bind exception_vectoring_unit evu_assertions evu_assertions_inst (.*);
